// ### far_side_model.sv
`timescale 1ns/1ps
`default_nettype none

// register file, flag byte and memory of the core
module far_side_model (
  input  wire logic        ref_clk,     // clock
  input  wire logic [2:0]  reg_sel,     // reg field
  input  wire logic        reg_we,      // reg write
  input  wire logic [7:0]  reg_wr_data, // reg data
  output logic      [7:0]  reg_rd_data, // reg read
  input  wire logic [15:0] mem_addr,    // address
  input  wire logic        mem_rd,      // read pulse
  input  wire logic        mem_we,      // write pulse
  input  wire logic [7:0]  mem_wr_data, // write data
  output logic      [7:0]  mem_rd_data, // read data
  input  wire logic        flags_we,    // flag write
  input  wire logic [7:0]  flags_out,   // new flags
  output logic      [7:0]  flags_in     // flag byte
);
  logic [7:0] regs [0:7];
  logic [7:0] mem [0:65535];
  logic [7:0] flags;

  // outside a read the bus shows the inverse, so a late sample is caught
  assign reg_rd_data = regs[reg_sel];
  assign mem_rd_data = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  assign flags_in = flags;

  // writes land at the edge that closes each pulse
  always @(posedge ref_clk) begin
    if (reg_we)
      regs[reg_sel] <= reg_wr_data;
    if (mem_we)
      mem[mem_addr] <= mem_wr_data;
    if (flags_we)
      flags <= flags_out;
  end
endmodule

`default_nettype wire

// ### shift_core.sv
`timescale 1ns/1ps
`default_nettype none

// pure combinational byte shifter with flag generation
module shift_core (
  input  wire logic [1:0] op,        // operation select
  input  wire logic [7:0] operand,   // source byte
  input  wire logic       carry_in,  // current carry flag
  output logic      [7:0] result,    // shifted byte
  output logic      [7:0] flags      // new flag byte
);

  // shift network and flags
  always_comb begin
    result = 8'h00;
    unique case (shift_unit_pkg::shift_op_t'(op))
      shift_unit_pkg::OP_RRTC: result = {carry_in, operand[7:1]};
      shift_unit_pkg::OP_ASL:  result = {operand[6:0], 1'b0};
      shift_unit_pkg::OP_ASR:  result = {operand[7], operand[7:1]};
      shift_unit_pkg::OP_LSR:  result = {1'b0, operand[7:1]};
    endcase
    flags = shift_unit_pkg::FLAGS_RESET;
    flags[shift_unit_pkg::FLAG_C] = (op == 2'b01) ? operand[7] : operand[0];
    // sign is simply bit 7; for the logical shift that bit is always zero
    flags[shift_unit_pkg::FLAG_S] = result[7];
    flags[shift_unit_pkg::FLAG_Z] = (result == 8'h00);
    flags[shift_unit_pkg::FLAG_P] = ~^result;
  end

endmodule

`default_nettype wire

// ### shift_rotate_right_unit.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module shift_rotate_right_unit (
  input  wire logic        ref_clk,    // core clock
  input  wire logic        srst,       // synchronous reset, active high
  input  wire logic        byte_valid, // instruction byte presented
  input  wire logic [7:0]  byte_in,    // instruction stream byte
  input  wire logic [7:0]  flags_in,   // current flag byte
  input  wire logic [7:0]  reg_rd_data,// selected register contents
  input  wire logic [15:0] ptr_pair,   // memory pointer pair
  input  wire logic [15:0] idx_first,  // first index register
  input  wire logic [15:0] idx_second, // second index register
  input  wire logic [7:0]  mem_rd_data,// memory read data
  output logic             byte_ready, // unit takes the next byte
  output logic [2:0]       reg_sel,    // register field to read or write
  output logic             reg_we,     // register write pulse
  output logic [7:0]       reg_wr_data,// register write data
  output logic [15:0]      mem_addr,   // memory address
  output logic             mem_rd,     // memory read pulse
  output logic             mem_we,     // memory write pulse
  output logic [7:0]       mem_wr_data,// memory write data
  output logic             flags_we,   // flag write pulse
  output logic [7:0]       flags_out,  // new flag byte
  output logic             done        // instruction complete pulse
);

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_CB     = 4'b0001,
    ST_OP     = 4'b0010,
    ST_IXCB   = 4'b0011,
    ST_DISP   = 4'b0100,
    ST_IXOP   = 4'b0101,
    ST_CALC   = 4'b0110,
    ST_MRD    = 4'b0111,
    ST_MWR    = 4'b1000,
    ST_REGOP  = 4'b1001,
    ST_MLAT   = 4'b1010
  } state_t;

  state_t      state;
  logic [2:0]  tcnt;        // states left in current machine cycle
  logic        use_index;   // indexed form in flight
  logic        idx_sel;     // 0 first, 1 second index register
  logic [7:0]  disp;
  logic [1:0]  op;
  logic [7:0]  operand;
  logic [7:0]  alu_result;
  logic [7:0]  alu_flags;
  logic        op_known;
  logic [15:0] idx_base;
  logic [15:0] eff_addr;

  shift_core u_core (
    .op       (op),
    .operand  (operand),
    .carry_in (flags_in[shift_unit_pkg::FLAG_C]),
    .result   (alu_result),
    .flags    (alu_flags)
  );

  // decode of the operation field, unknown codes fall outside this unit
  always_comb begin
    op_known = 1'b1;
    unique case (byte_in[7:3])
      shift_unit_pkg::OPF_RRTC: op_known = 1'b1;
      shift_unit_pkg::OPF_ASL:  op_known = 1'b1;
      shift_unit_pkg::OPF_ASR:  op_known = 1'b1;
      shift_unit_pkg::OPF_LSR:  op_known = 1'b1;
      default:                  op_known = 1'b0;
    endcase
  end

  // signed displacement added to the chosen index register
  assign idx_base = idx_sel ? idx_second : idx_first;
  assign eff_addr = idx_base + {{8{disp[7]}}, disp};

  // main sequencer: prefix decode and machine-cycle timing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state       <= ST_IDLE;
      tcnt        <= 3'h0;
      use_index   <= 1'b0;
      idx_sel     <= 1'b0;
      disp        <= shift_unit_pkg::BYTE_RESET;
      op          <= 2'b00;
      operand     <= shift_unit_pkg::BYTE_RESET;
      byte_ready  <= 1'b1;
      reg_sel     <= 3'h0;
      reg_we      <= 1'b0;
      reg_wr_data <= shift_unit_pkg::BYTE_RESET;
      mem_addr    <= 16'h0000;
      mem_rd      <= 1'b0;
      mem_we      <= 1'b0;
      mem_wr_data <= shift_unit_pkg::BYTE_RESET;
      flags_we    <= 1'b0;
      flags_out   <= shift_unit_pkg::FLAGS_RESET;
      done        <= 1'b0;
    end else begin
      // pulses last one cycle
      reg_we   <= 1'b0;
      mem_rd   <= 1'b0;
      mem_we   <= 1'b0;
      flags_we <= 1'b0;
      done     <= 1'b0;
      if (tcnt != 3'h0) begin
        // stall until the machine cycle's states are spent
        tcnt <= tcnt - 3'h1;
        byte_ready <= (tcnt == 3'h1) &&
                      (state inside {ST_IDLE, ST_CB, ST_OP, ST_IXCB, ST_DISP, ST_IXOP});
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (byte_valid && byte_ready) begin
              use_index <= 1'b0;
              if (byte_in == shift_unit_pkg::CB_PREFIX) begin
                state <= ST_OP;
                byte_ready <= 1'b0;
                tcnt <= shift_unit_pkg::MC_FETCH_PFX - 3'h1;
              end else if (byte_in == shift_unit_pkg::IDX1_PREFIX ||
                           byte_in == shift_unit_pkg::IDX2_PREFIX) begin
                idx_sel <= (byte_in == shift_unit_pkg::IDX2_PREFIX);
                use_index <= 1'b1;
                state <= ST_IXCB;
                byte_ready <= 1'b0;
                tcnt <= shift_unit_pkg::MC_FETCH_PFX - 3'h1;
              end
            end
          end
          ST_IXCB: begin
            if (byte_valid && byte_ready) begin
              byte_ready <= 1'b0;
              if (byte_in == shift_unit_pkg::CB_PREFIX) begin
                state <= ST_DISP;
                tcnt <= shift_unit_pkg::MC_FETCH_CB - 3'h1;
              end else begin
                state <= ST_IDLE;  // not ours, hand back
                byte_ready <= 1'b1;
              end
            end
          end
          ST_DISP: begin
            if (byte_valid && byte_ready) begin
              disp <= byte_in;
              byte_ready <= 1'b0;
              state <= ST_IXOP;
              tcnt <= shift_unit_pkg::MC_DISP - 3'h1;
            end
          end
          ST_IXOP: begin
            // the operation byte's register field is ignored here:
            // indexed forms always address memory
            if (byte_valid && byte_ready) begin
              byte_ready <= 1'b0;
              if (op_known) begin
                op <= (byte_in[7:3] == shift_unit_pkg::OPF_RRTC) ? 2'b00 :
                      (byte_in[7:3] == shift_unit_pkg::OPF_ASL)  ? 2'b01 :
                      (byte_in[7:3] == shift_unit_pkg::OPF_ASR)  ? 2'b10 : 2'b11;
                mem_addr <= eff_addr;
                state <= ST_MRD;
                tcnt <= shift_unit_pkg::MC_OPCALC - 3'h1;
              end else begin
                state <= ST_IDLE;
                byte_ready <= 1'b1;
              end
            end
          end
          ST_OP: begin
            if (byte_valid && byte_ready) begin
              byte_ready <= 1'b0;
              if (op_known) begin
                op <= (byte_in[7:3] == shift_unit_pkg::OPF_RRTC) ? 2'b00 :
                      (byte_in[7:3] == shift_unit_pkg::OPF_ASL)  ? 2'b01 :
                      (byte_in[7:3] == shift_unit_pkg::OPF_ASR)  ? 2'b10 : 2'b11;
                reg_sel <= byte_in[2:0];
                if (byte_in[2:0] == shift_unit_pkg::REG_MEM) begin
                  mem_addr <= ptr_pair;
                  state <= ST_MRD;
                  tcnt <= shift_unit_pkg::MC_FETCH_CB - 3'h1;
                end else begin
                  // the operand load cycle belongs to this machine cycle; write-back in ST_CALC comes after it
                  state <= ST_REGOP;
                  tcnt <= shift_unit_pkg::MC_FETCH_CB - 3'h2;
                end
              end else begin
                state <= ST_IDLE;
                byte_ready <= 1'b1;
              end
            end
          end
          ST_REGOP: begin
            // register form: operand read here; result and flags written back together next cycle in ST_CALC
            operand <= reg_rd_data;
            state <= ST_CALC;
          end
          ST_MRD: begin
            // raise the strobe first; the byte is only valid while it stands
            mem_rd <= 1'b1;
            state <= ST_MLAT;
          end
          ST_MLAT: begin
            operand <= mem_rd_data;
            state <= ST_CALC;
            // the strobe and latch cycles are already two states of the read cycle
            tcnt <= (use_index ? shift_unit_pkg::MC_MEMRD
                               : shift_unit_pkg::MC_PTR_RD) - 3'h2;
          end
          ST_CALC: begin
            flags_out <= alu_flags;
            flags_we  <= 1'b1;
            if (reg_sel == shift_unit_pkg::REG_MEM || use_index) begin
              mem_wr_data <= alu_result;
              mem_we <= 1'b1;
              state <= ST_MWR;
              tcnt <= shift_unit_pkg::MC_MEMWR - 3'h1;
            end else begin
              reg_wr_data <= alu_result;
              reg_we <= 1'b1;
              done <= 1'b1;
              byte_ready <= 1'b1;
              state <= ST_IDLE;
            end
          end
          ST_MWR: begin
            done <= 1'b1;
            byte_ready <= 1'b1;
            use_index <= 1'b0;
            reg_sel <= 3'h0;
            state <= ST_IDLE;
          end
          default: begin
            state <= ST_IDLE;
            byte_ready <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### shift_unit_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// port checker; the write-back is judged against the byte the read fetched
module shift_unit_assertions (
  input wire logic        ref_clk,     // clock
  input wire logic        srst,        // reset
  input wire logic [2:0]  reg_sel,     // reg field
  input wire logic        reg_we,      // reg write
  input wire logic [7:0]  reg_wr_data, // reg result
  input wire logic [15:0] mem_addr,    // address
  input wire logic        mem_rd,      // mem read
  input wire logic [7:0]  mem_rd_data, // read byte
  input wire logic        mem_we,      // mem write
  input wire logic [7:0]  mem_wr_data, // mem result
  input wire logic        flags_we,    // flag write
  input wire logic [7:0]  flags_out    // new flags
);
  logic [15:0] rd_addr;
  logic [7:0]  rd_byte;

  default clocking cb_main @(posedge ref_clk); endclocking
  default disable iff (srst);

  // latch the read so the write can be tied to it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_addr <= 16'h0000;
      rd_byte <= 8'h00;
    end else if (mem_rd) begin
      rd_addr <= mem_addr;
      rd_byte <= mem_rd_data;
    end
  end

  chk_hn_clear: assert property (flags_we |-> !flags_out[4] && !flags_out[1])
    else $error("half-carry or subtract set");
  chk_reg_zero: assert property (reg_we |-> flags_we && flags_out[6] == (reg_wr_data == 8'h00))
    else $error("zero flag wrong");
  chk_reg_parity: assert property (reg_we |-> flags_out[2] == ~^reg_wr_data)
    else $error("parity flag wrong");
  chk_mem_sign: assert property (mem_we |-> flags_we && flags_out[7] == mem_wr_data[7])
    else $error("sign flag wrong");
  chk_reg_field: assert property (reg_we |-> reg_sel != 3'h6)
    else $error("register write with memory code");
  chk_rmw_order: assert property (mem_rd |-> ##[1:8] mem_we)
    else $error("no write-back after read");
  chk_rmw_addr: assert property (mem_we |-> mem_addr == rd_addr)
    else $error("write-back to other address");
  chk_mem_carry: assert property (mem_we |-> (mem_wr_data[6:0] == rd_byte[7:1] &&
    flags_out[0] == rd_byte[0]) || (mem_wr_data == {rd_byte[6:0], 1'b0} &&
    flags_out[0] == rd_byte[7]))
    else $error("carry or shift wrong");

  cover property (reg_we);
  cover property (mem_rd ##[1:8] mem_we);
  cover property (mem_we && flags_out[6]);
endmodule

bind shift_rotate_right_unit shift_unit_assertions chk_i (.ref_clk, .srst, .reg_sel, .reg_we,
  .reg_wr_data, .mem_addr, .mem_rd, .mem_rd_data, .mem_we, .mem_wr_data, .flags_we, .flags_out);

`default_nettype wire

// ### shift_unit_pkg.sv
package shift_unit_pkg;

  // prefix and operation bytes
  localparam logic [7:0] CB_PREFIX   = 8'hcb;
  localparam logic [7:0] IDX1_PREFIX = 8'hdd;
  localparam logic [7:0] IDX2_PREFIX = 8'hfd;
  // operation field, bits 7:3 of the operation byte
  localparam logic [4:0] OPF_RRTC    = 5'h03;  // 0x18..0x1f, memory form 1e
  localparam logic [4:0] OPF_ASL     = 5'h04;  // 0x20..0x27, memory form 26
  localparam logic [4:0] OPF_ASR     = 5'h05;  // 0x28..0x2f
  localparam logic [4:0] OPF_LSR     = 5'h07;  // 0x38..0x3f
  localparam logic [2:0] REG_MEM     = 3'h6;   // memory operand code
  localparam logic [2:0] REG_ACC     = 3'h7;

  // machine-cycle state counts for indexed forms (23 total)
  localparam logic [2:0] MC_FETCH_PFX = 3'h4;
  localparam logic [2:0] MC_FETCH_CB  = 3'h4;
  localparam logic [2:0] MC_DISP      = 3'h3;
  localparam logic [2:0] MC_OPCALC    = 3'h5;
  localparam logic [2:0] MC_MEMRD     = 3'h4;
  localparam logic [2:0] MC_MEMWR     = 3'h3;
  // register form: 4,4 ; pointer memory form: 4,4,4,3
  localparam logic [2:0] MC_PTR_RD    = 3'h4;

  // flag bit positions in the flag byte
  localparam int FLAG_C = 0;
  localparam int FLAG_N = 1;
  localparam int FLAG_P = 2;
  localparam int FLAG_H = 4;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 7;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET  = 8'h00;

  typedef enum logic [1:0] {
    OP_RRTC = 2'b00,
    OP_ASL  = 2'b01,
    OP_ASR  = 2'b10,
    OP_LSR  = 2'b11
  } shift_op_t;

endpackage

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end

module tb;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        byte_valid = 1'b0;
  logic [7:0]  byte_in = 8'h00;
  logic [15:0] ptr_pair = 16'h4343;
  logic [15:0] idx_first = 16'h1000;
  logic [15:0] idx_second = 16'h2080;
  logic [7:0]  flags_in, reg_rd_data, mem_rd_data, reg_wr_data, mem_wr_data, flags_out;
  logic [2:0]  reg_sel;
  logic [15:0] mem_addr;
  logic        byte_ready, reg_we, mem_rd, mem_we, flags_we, done;
  int          err_count = 0;
  int          checked = 0;

  shift_rotate_right_unit uut (.ref_clk, .srst, .byte_valid, .byte_in, .flags_in,
    .reg_rd_data, .ptr_pair, .idx_first, .idx_second, .mem_rd_data, .byte_ready, .reg_sel,
    .reg_we, .reg_wr_data, .mem_addr, .mem_rd, .mem_we, .mem_wr_data, .flags_we, .flags_out,
    .done);
  far_side_model far (.ref_clk, .reg_sel, .reg_we, .reg_wr_data, .reg_rd_data, .mem_addr,
    .mem_rd, .mem_we, .mem_wr_data, .mem_rd_data, .flags_we, .flags_out, .flags_in);

  always #12.5 ref_clk = ~ref_clk;

  task automatic close_out();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hold the byte until the unit takes it; ready is looked at mid-cycle
  task automatic send(input logic [7:0] b);
    int n = 0;
    byte_valid <= 1'b1;
    byte_in <= b;
    @(negedge ref_clk);
    while (byte_ready !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
  endtask

  // one instruction: preload operand, H and N set, then judge timing, result and flags
  task automatic exec(input logic [7:0] pfx, input logic [7:0] d, input logic [7:0] opb,
                      input logic [7:0] v, input logic c);
    logic [7:0]  r;
    logic        co;
    logic        mf;
    logic [15:0] a;
    int          n = 0;
    int          lat;
    @(posedge ref_clk);
    case (opb[7:3])
      5'h03: r = {c, v[7:1]};
      5'h04: r = {v[6:0], 1'b0};
      5'h05: r = {v[7], v[7:1]};
      default: r = {1'b0, v[7:1]};
    endcase
    co = (opb[7:3] == 5'h04) ? v[7] : v[0];
    mf = pfx != 8'h00 || opb[2:0] == 3'h6;
    // machine cycles left after the operation byte, plus the negedge that sees done
    if (pfx != 8'h00)
      lat = int'(shift_unit_pkg::MC_OPCALC) + int'(shift_unit_pkg::MC_MEMRD) +
            int'(shift_unit_pkg::MC_MEMWR) + 1;
    else if (mf)
      lat = int'(shift_unit_pkg::MC_FETCH_CB) + int'(shift_unit_pkg::MC_PTR_RD) +
            int'(shift_unit_pkg::MC_MEMWR) + 1;
    else
      lat = int'(shift_unit_pkg::MC_FETCH_CB) + 1;
    a = (pfx == 8'hdd) ? idx_first + {{8{d[7]}}, d} :
        (pfx == 8'hfd) ? idx_second + {{8{d[7]}}, d} : ptr_pair;
    far.flags = {7'b0001001, c};
    if (mf) far.mem[a] = v;
    else far.regs[opb[2:0]] = v;
    if (pfx != 8'h00) send(pfx);
    send(8'hcb);
    if (pfx != 8'h00) send(d);
    send(opb);
    byte_valid <= 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (done !== 1'b1 && n < 40);
    `CHK("done", 1'b1, done)
    `CHK("latency", lat, n)
    `CHK("ready", 1'b1, byte_ready)
    @(negedge ref_clk);
    `CHK("result", r, mf ? far.mem[a] : far.regs[opb[2:0]])
    `CHK("flags", {r[7], r == 8'h00, 3'b000, ~^r, 1'b0, co}, far.flags & 8'hd7)
  endtask

  // all four ops on every register code
  task automatic t_reg_ops();
    logic [4:0] opf [4] = '{5'h03, 5'h04, 5'h05, 5'h07};
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 8; k++) begin
        if (k != 6) exec(8'h00, 8'h00, {opf[i], k[2:0]}, 8'h8f ^ (8'h3b * k[7:0]), k[0]);
      end
    end
  endtask

  // pointer forms with the coded second bytes
  task automatic t_ptr_forms();
    exec(8'h00, 8'h00, 8'h1e, 8'hdd, 1'b0);
    exec(8'h00, 8'h00, 8'h26, 8'hb1, 1'b1);
    exec(8'h00, 8'h00, 8'h2e, 8'h80, 1'b0);
    exec(8'h00, 8'h00, 8'h3e, 8'hff, 1'b1);
  endtask

  // both index prefixes, displacements at the signed edges
  task automatic t_idx_forms();
    exec(8'hdd, 8'h03, 8'h2e, 8'hb8, 1'b0);
    exec(8'hfd, 8'h80, 8'h1e, 8'h01, 1'b0);
    exec(8'hdd, 8'h7f, 8'h3e, 8'h01, 1'b1);
    exec(8'hfd, 8'hfe, 8'h26, 8'h80, 1'b0);
  endtask

  // foreign operation bytes, plain and indexed, are handed back with no write
  task automatic t_foreign();
    logic hit = 1'b0;
    @(posedge ref_clk);
    send(8'hcb);
    send(8'h06);
    send(8'hfd);
    send(8'hcb);
    send(8'h05);
    send(8'h0e);
    byte_valid <= 1'b0;
    repeat (8) begin
      @(negedge ref_clk);
      if (done !== 1'b0 || reg_we !== 1'b0 || mem_we !== 1'b0) hit = 1'b1;
    end
    `CHK("foreign ready", 1'b1, byte_ready)
    `CHK("foreign write", 1'b0, hit)
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    t_reg_ops();
    t_ptr_forms();
    t_idx_forms();
    t_foreign();
    close_out();
  end

  // about 40 instructions of under 40 cycles each
  initial begin
    repeat (4000) @(posedge ref_clk);
    err_count++;
    close_out();
  end
endmodule

`default_nettype wire
